/* File: design/ccs_defs.vh */
// Constants for the contactless command sequencer.
// Functional notes
// - Code 0000 cancels any running command and enters idle.
// - Config loads 25 FIFO bytes into the internal configuration buffer.
// - First identifier byte 0 is stored as 08h; its check byte is computed.
// - Config started with empty FIFO copies 25 buffer bytes back to FIFO.
// - Configuration buffer survives hard power-down; firmware loads it after power-up.
// - Config and random-ID commands end by themselves, returning to idle.
// - Code 0010 writes 10 random bytes over the third-identifier bytes.
// - Code 0011 streams FIFO bytes into CRC endlessly, result to CRC register.
// - CRC start value comes from the preset select at command start.
// - With self-test bit set, CRC command runs self-test writing results to FIFO.
// - Code 0100 transmits FIFO contents, ends when FIFO empties.
// - Code 0111 keeps the running command, updates other command bits.
// - Code 1000 receives and ends when the stream ends.
// - Multi-receive bit stops receive ending and keeps transceive receiving.
// - Code 1100 alternates send and receive; initiator bit picks first step.
// - Code 1101 needs initiator 0; mode detection runs unless disabled.
// - Activation resets without RF field, ends into transceive, rewrite restarts.
// - Type A activation forces CRC enables; polling uses the register enables.
// - Code 1110 runs card authentication, code 1111 performs soft reset.
// - A new command code interrupts the running one; FIFO is never cleared.
// - Idle flag sets when a command finishes and the register returns to idle.
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH
`define CCS_CMD_IDLE 4'h0
`define CCS_CMD_CONFIG 4'h1
`define CCS_CMD_RANDOM 4'h2
`define CCS_CMD_CRC 4'h3
`define CCS_CMD_TRANSMIT 4'h4
`define CCS_CMD_KEEP 4'h7
`define CCS_CMD_RECEIVE 4'h8
`define CCS_CMD_SELF_TEST_BIT 4'h9
`define CCS_CMD_TRANSCEIVE 4'hc
`define CCS_CMD_AUTOCOLL 4'hd
`define CCS_CMD_AUTH 4'he
`define CCS_CMD_SOFTRESET 4'hf
`define CCS_CFG_BYTES 5'd25
`define CCS_CFG_LAST 5'd24
`define CCS_ID1_FIXED 8'h08
`define CCS_ID1_CHECK_IDX 5'd25
`define CCS_ID3_FIRST 5'd2
`define CCS_ID3_COUNT 4'd10
`define CCS_ID1_LEN 5'd3
`define CCS_ID12_LEN 5'd9
`define CCS_ID2_FIRST 5'd8
`define CCS_POLL_B0 8'h01
`define CCS_POLL_B1 8'hfe
`define CCS_ADDR_COMMAND 12'h000
`define CCS_ADDR_CONTROL 12'h004
`define CCS_ADDR_STATUS 12'h008
`define CCS_ADDR_CRC 12'h00c
`define CCS_ADDR_FLAGS 12'h010
`define CCS_ADDR_FIFO 12'h014
`define CCS_CRC_PRESET0 16'h0000
`define CCS_CRC_PRESET1 16'h6363
`define CCS_CRC_PRESET2 16'ha671
`define CCS_CRC_PRESET3 16'hffff
`define CCS_CRC_POLY 16'h8408
`define CCS_LFSR_SEED 16'hace1
`define CCS_RESP_OKAY 2'b00
`define CCS_RESP_SLVERR 2'b10
`endif

/* File: design/ccs_sequencer.v */
// Command sequencer of the contactless unit with an AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module ccs_sequencer #(
  parameter FIFO_DEPTH = 64
)
(
  input wire sys_clk,
  input wire rst,
  input wire hard_powerdown_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire rf_field_present,
  input wire rx_frame_end,
  input wire [7:0] rx_data,
  input wire rx_data_valid,
  input wire tx_byte_taken,
  input wire mode_detected,
  input wire type_a_mode,
  input wire auth_done,
  output reg tx_active,
  output reg [7:0] tx_data,
  output reg rx_active,
  output reg mode_detect_active,
  output reg crc_force,
  output reg soft_reset_pulse
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CFG_LOAD = 3'd1;
  localparam ST_CFG_READ = 3'd2;
  localparam ST_RANDOM = 3'd3;
  localparam ST_RUN = 3'd4;
  localparam ST_SEND = 3'd5;
  localparam ST_RECV = 3'd6;

  // Configuration buffer, with one extra slot for the computed check byte.
  // It sits outside the rst domain so that a hard power-down keeps it.
  reg [7:0] cfg_buf [0:25];
  reg [7:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [5:0] fifo_rd;
  reg [5:0] fifo_wr;
  reg [6:0] fifo_cnt;
  reg [3:0] active_cmd;
  reg [2:0] state;
  reg [4:0] idx;
  reg receiver_off_bit;
  reg power_down_bit;
  reg initiator_bit;
  reg multi_receive_bit;
  reg mode_detect_disable;
  reg [1:0] crc_start_value_sel;
  reg self_test_bit;
  reg tx_crc_enable;
  reg rx_crc_enable;
  reg start_send_bit;
  reg [15:0] crc_result_register;
  reg [15:0] lfsr;
  reg idle_flag;
  reg field_on_flag;
  reg field_off_flag;
  reg rf_prev;
  reg aw_hold;
  reg w_hold;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg cmd_write;
  reg [3:0] new_cmd;
  reg fifo_push_sw;
  reg fifo_pop_sw;
  reg wr_ok;
  wire fifo_empty;
  wire fifo_full;
  reg seq_push;
  reg [7:0] seq_push_data;
  reg seq_pop;

  assign fifo_empty = (fifo_cnt == 7'd0);
  assign fifo_full = (fifo_cnt == FIFO_DEPTH);

  function [15:0] crc_step;
    input [15:0] crc_in;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc_in ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1)
        c = c[0] ? ((c >> 1) ^ `CCS_CRC_POLY) : (c >> 1);
      crc_step = c;
    end
  endfunction

  function [15:0] crc_preset;
    input [1:0] sel;
    begin
      case (sel)
        2'd0: crc_preset = `CCS_CRC_PRESET0;
        2'd1: crc_preset = `CCS_CRC_PRESET1;
        2'd2: crc_preset = `CCS_CRC_PRESET2;
        default: crc_preset = `CCS_CRC_PRESET3;
      endcase
    end
  endfunction

  // The third identifier is scattered over the buffer, so the polling header bytes survive.
  function [4:0] id3_slot;
    input [4:0] k;
    begin
      if (k < `CCS_ID1_LEN)
        id3_slot = `CCS_ID3_FIRST + k;
      else if (k < `CCS_ID12_LEN)
        id3_slot = `CCS_ID2_FIRST + k - `CCS_ID1_LEN;
      else
        id3_slot = `CCS_CFG_LAST;
    end
  endfunction

  // AXI4-Lite write side: address and data are latched independently.
  always @*
  begin
    wr_ok = aw_hold && w_hold && !s_axi_bvalid;
    cmd_write = wr_ok && (aw_addr == `CCS_ADDR_COMMAND) && w_data[3:0] != `CCS_CMD_KEEP;
    new_cmd = w_data[3:0];
    fifo_push_sw = wr_ok && (aw_addr == `CCS_ADDR_FIFO) && !fifo_full;
    fifo_pop_sw = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `CCS_ADDR_FIFO)
      && !fifo_empty;
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CCS_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr <= s_axi_awaddr;
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data <= s_axi_wdata;
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_ok)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= `CCS_ADDR_FIFO && aw_addr[1:0] == 2'b00) ?
          `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCS_RESP_OKAY;
        case (s_axi_araddr)
          `CCS_ADDR_COMMAND: s_axi_rdata <= {26'h0, receiver_off_bit, power_down_bit,
            active_cmd};
          `CCS_ADDR_CONTROL: s_axi_rdata <= {23'h0, start_send_bit, rx_crc_enable,
            tx_crc_enable, self_test_bit, crc_start_value_sel, mode_detect_disable,
            multi_receive_bit, initiator_bit};
          `CCS_ADDR_STATUS: s_axi_rdata <= {22'h0, fifo_cnt, state};
          `CCS_ADDR_CRC: s_axi_rdata <= {16'h0, crc_result_register};
          `CCS_ADDR_FLAGS: s_axi_rdata <= {29'h0, field_off_flag, field_on_flag, idle_flag};
          `CCS_ADDR_FIFO: s_axi_rdata <= {24'h0, fifo_mem[fifo_rd]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // FIFO shared by software and the sequencer; software access wins a push.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fifo_rd <= 6'd0;
      fifo_wr <= 6'd0;
      fifo_cnt <= 7'd0;
    end
    else
    begin
      if (fifo_push_sw || (seq_push && !fifo_full))
      begin
        fifo_mem[fifo_wr] <= fifo_push_sw ? w_data[7:0] : seq_push_data;
        fifo_wr <= fifo_wr + 6'd1;
      end
      if (fifo_pop_sw || (seq_pop && !fifo_empty))
        fifo_rd <= fifo_rd + 6'd1;
      fifo_cnt <= fifo_cnt + {6'd0, (fifo_push_sw || (seq_push && !fifo_full))}
        - {6'd0, (fifo_pop_sw || (seq_pop && !fifo_empty))};
    end
  end

  // Sequencer data movements decided combinationally from state.
  always @*
  begin
    seq_push = 1'b0;
    seq_push_data = 8'h00;
    seq_pop = 1'b0;
    if (!fifo_pop_sw)
    begin
      case (state)
        ST_CFG_LOAD: seq_pop = !fifo_empty;
        ST_CFG_READ:
        begin
          seq_push = !fifo_push_sw;
          seq_push_data = cfg_buf[idx];
        end
        ST_RUN:
        begin
          seq_pop = (active_cmd == `CCS_CMD_CRC) && !self_test_bit;
          seq_push = (active_cmd == `CCS_CMD_CRC) && self_test_bit && !fifo_push_sw
            && idx != `CCS_CFG_LAST;
          seq_push_data = lfsr[7:0];
        end
        ST_SEND: seq_pop = tx_byte_taken;
        ST_RECV:
        begin
          seq_push = rx_data_valid && !fifo_push_sw;
          seq_push_data = rx_data;
        end
        default: seq_pop = 1'b0;
      endcase
    end
  end

  // Configuration buffer writes; no reset so contents outlive power-down.
  always @(posedge sys_clk)
  begin
    if (state == ST_CFG_LOAD && seq_pop)
    begin
      cfg_buf[idx] <= (idx == 5'd2) ? `CCS_ID1_FIXED : fifo_mem[fifo_rd];
      if (idx == `CCS_CFG_LAST)
        cfg_buf[`CCS_ID1_CHECK_IDX] <= `CCS_ID1_FIXED ^ cfg_buf[3] ^ cfg_buf[4];
    end
    if (state == ST_RANDOM)
      cfg_buf[id3_slot(idx)] <= lfsr[7:0];
  end

  // Command state machine.
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      active_cmd <= `CCS_CMD_IDLE;
      state <= ST_IDLE;
      idx <= 5'd0;
      receiver_off_bit <= 1'b0;
      power_down_bit <= 1'b0;
      initiator_bit <= 1'b0;
      multi_receive_bit <= 1'b0;
      mode_detect_disable <= 1'b0;
      crc_start_value_sel <= 2'd0;
      self_test_bit <= 1'b0;
      tx_crc_enable <= 1'b0;
      rx_crc_enable <= 1'b0;
      start_send_bit <= 1'b0;
      crc_result_register <= 16'h0000;
      lfsr <= `CCS_LFSR_SEED;
      idle_flag <= 1'b0;
      field_on_flag <= 1'b0;
      field_off_flag <= 1'b0;
      rf_prev <= 1'b0;
      tx_active <= 1'b0;
      tx_data <= 8'h00;
      rx_active <= 1'b0;
      mode_detect_active <= 1'b0;
      crc_force <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      rf_prev <= rf_field_present;
      soft_reset_pulse <= 1'b0;
      if (rf_field_present && !rf_prev)
        field_on_flag <= 1'b1;
      else if (wr_ok && aw_addr == `CCS_ADDR_FLAGS && w_data[1])
        field_on_flag <= 1'b0;
      if (!rf_field_present && rf_prev)
        field_off_flag <= 1'b1;
      else if (wr_ok && aw_addr == `CCS_ADDR_FLAGS && w_data[2])
        field_off_flag <= 1'b0;
      if (wr_ok && aw_addr == `CCS_ADDR_CONTROL)
      begin
        initiator_bit <= w_data[0];
        multi_receive_bit <= w_data[1];
        mode_detect_disable <= w_data[2];
        crc_start_value_sel <= w_data[4:3];
        self_test_bit <= w_data[5];
        tx_crc_enable <= w_data[6];
        rx_crc_enable <= w_data[7];
        start_send_bit <= w_data[8];
      end
      if (wr_ok && aw_addr == `CCS_ADDR_COMMAND)
      begin
        receiver_off_bit <= w_data[5];
        power_down_bit <= w_data[4];
      end
      if (state == ST_RUN && active_cmd == `CCS_CMD_CRC && seq_pop && !fifo_empty)
        crc_result_register <= crc_step(crc_result_register, fifo_mem[fifo_rd]);
      if (state == ST_RUN && seq_push && !fifo_full)
        idx <= idx + 5'd1;
      if (cmd_write)
      begin
        active_cmd <= new_cmd;
        idx <= 5'd0;
        tx_active <= 1'b0;
        rx_active <= 1'b0;
        mode_detect_active <= 1'b0;
        crc_force <= 1'b0;
        case (new_cmd)
          `CCS_CMD_CONFIG:
            state <= fifo_empty ? ST_CFG_READ : ST_CFG_LOAD;
          `CCS_CMD_RANDOM: state <= ST_RANDOM;
          `CCS_CMD_CRC:
          begin
            crc_result_register <= crc_preset(crc_start_value_sel);
            state <= ST_RUN;
          end
          `CCS_CMD_TRANSMIT: state <= ST_SEND;
          `CCS_CMD_RECEIVE: state <= ST_RECV;
          `CCS_CMD_TRANSCEIVE: state <= initiator_bit ? ST_SEND : ST_RECV;
          `CCS_CMD_AUTOCOLL: state <= ST_RUN;
          `CCS_CMD_SELF_TEST_BIT: state <= ST_RUN;
          `CCS_CMD_AUTH: state <= ST_RUN;
          `CCS_CMD_SOFTRESET:
          begin
            soft_reset_pulse <= 1'b1;
            active_cmd <= `CCS_CMD_IDLE;
            state <= ST_IDLE;
            idle_flag <= 1'b1;
          end
          default:
          begin
            active_cmd <= `CCS_CMD_IDLE;
            state <= ST_IDLE;
          end
        endcase
      end
      else
      begin
        if (wr_ok && aw_addr == `CCS_ADDR_FLAGS && w_data[0])
          idle_flag <= 1'b0;
        case (state)
          ST_CFG_LOAD:
            if (seq_pop)
            begin
              idx <= idx + 5'd1;
              if (idx == `CCS_CFG_LAST)
              begin
                state <= ST_IDLE;
                active_cmd <= `CCS_CMD_IDLE;
                idle_flag <= 1'b1;
              end
            end
          ST_CFG_READ:
            if (seq_push && !fifo_full)
            begin
              idx <= idx + 5'd1;
              if (idx == `CCS_CFG_LAST)
              begin
                state <= ST_IDLE;
                active_cmd <= `CCS_CMD_IDLE;
                idle_flag <= 1'b1;
              end
            end
          ST_RANDOM:
          begin
            idx <= idx + 5'd1;
            if (idx == {1'b0, `CCS_ID3_COUNT} - 5'd1)
            begin
              state <= ST_IDLE;
              active_cmd <= `CCS_CMD_IDLE;
              idle_flag <= 1'b1;
            end
          end
          ST_SEND:
          begin
            tx_active <= (active_cmd != `CCS_CMD_TRANSCEIVE) || start_send_bit;
            tx_data <= fifo_mem[fifo_rd];
            if (fifo_empty && ((active_cmd != `CCS_CMD_TRANSCEIVE) || start_send_bit))
            begin
              tx_active <= 1'b0;
              start_send_bit <= 1'b0;
              if (active_cmd == `CCS_CMD_TRANSCEIVE)
                state <= ST_RECV;
              else
              begin
                state <= ST_IDLE;
                active_cmd <= `CCS_CMD_IDLE;
                idle_flag <= 1'b1;
              end
            end
          end
          ST_RECV:
          begin
            rx_active <= !receiver_off_bit;
            if (rx_frame_end && !multi_receive_bit)
            begin
              rx_active <= 1'b0;
              if (active_cmd == `CCS_CMD_TRANSCEIVE)
                state <= ST_SEND;
              else
              begin
                state <= ST_IDLE;
                active_cmd <= `CCS_CMD_IDLE;
                idle_flag <= 1'b1;
              end
            end
          end
          ST_RUN:
            if (active_cmd == `CCS_CMD_AUTOCOLL)
            begin
              mode_detect_active <= !mode_detect_disable && !initiator_bit;
              rx_active <= rf_field_present;
              crc_force <= type_a_mode;
              if (!rf_field_present)
                idx <= 5'd0;
              else if (mode_detected && rx_frame_end)
              begin
                mode_detect_active <= 1'b0;
                crc_force <= 1'b0;
                active_cmd <= `CCS_CMD_TRANSCEIVE;
                state <= ST_RECV;
              end
            end
            else if (active_cmd == `CCS_CMD_AUTH && auth_done)
            begin
              state <= ST_IDLE;
              active_cmd <= `CCS_CMD_IDLE;
              idle_flag <= 1'b1;
            end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/ccs_checker.sv */
// Port checker of the command sequencer.
`timescale 1ns/10ps
`default_nettype none
module ccs_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic mode_detect_active,
  input wire logic crc_force,
  input wire logic soft_reset_pulse
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  AST_SRST: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");
  AST_BONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_AWBLK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  AST_RONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  AST_RNEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_SLVERR: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  AST_TXRX: assert property (!(tx_active && rx_active))
    else $error("send and receive at once");
  AST_CRCF: assert property (crc_force |-> !tx_active)
    else $error("crc override during transmit");
endmodule
`default_nettype wire

/* File: tb/ccs_link_model.sv */
// Model of the radio link behind the sequencer.
`timescale 1ns/10ps
`default_nettype none
module ccs_link_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tx_active,
  input wire logic frame_req,
  output logic tx_byte_taken,
  output logic rx_data_valid,
  output logic rx_frame_end,
  output logic [7:0] rx_data
);
  logic [1:0] div;
  logic [1:0] ph;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div <= 2'd0;
      ph <= 2'd0;
      tx_byte_taken <= 1'b0;
      rx_data_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      div <= div + 2'd1;
      tx_byte_taken <= tx_active && div == 2'd3;
      ph <= frame_req ? 2'd1 : (ph == 2'd0 || ph == 2'd3) ? 2'd0 : ph + 2'd1;
      rx_data_valid <= ph == 2'd1;
      rx_frame_end <= ph == 2'd2;
      // Outside a byte the data line keeps changing, so stale data never looks valid.
      rx_data <= (ph == 2'd1) ? 8'h5a : ~rx_data;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb_contactless_command_sequencer.sv */
// Register-level testbench of the command sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.vh"
module tb_contactless_command_sequencer;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] aw = 12'h0;
  logic [11:0] ar = 12'h0;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic rf = 1'b0, det = 1'b0, freq = 1'b0, ta = 1'b1, ad = 1'b0;
  wire awr, wrd, bv, arr, rv, ttk, rxv, rxe, txa, rxa, mda, crf, srp;
  wire [1:0] rresp;
  wire [31:0] rdata;
  wire [7:0] rxd, txd;
  logic [7:0] last_tx;
  int srp_n = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  int err_total = 0;
  int checks_done = 0;
  int i;
  ccs_sequencer dut (.sys_clk(sys_clk), .rst(rst), .hard_powerdown_n(1'b1),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrd), .rf_field_present(rf), .rx_frame_end(rxe), .rx_data(rxd),
    .rx_data_valid(rxv), .tx_byte_taken(ttk), .mode_detected(det), .type_a_mode(ta),
    .auth_done(ad), .tx_active(txa), .tx_data(txd), .rx_active(rxa),
    .mode_detect_active(mda), .crc_force(crf), .soft_reset_pulse(srp));
  ccs_link_model lm (.sys_clk(sys_clk), .rst(rst), .tx_active(txa), .frame_req(freq),
    .tx_byte_taken(ttk), .rx_data_valid(rxv), .rx_frame_end(rxe), .rx_data(rxd));
  initial forever #5 sys_clk = ~sys_clk;
  // A taken byte is the head that stood on the edge the take was seen.
  always @(posedge sys_clk)
  begin
    if (ttk === 1'b1) last_tx <= txd;
    if (srp === 1'b1) srp_n <= srp_n + 1;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    aw <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wrd === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    br <= 1'b0;
  endtask
  task automatic rdt(input logic [11:0] a);
    @(posedge sys_clk);
    ar <= a; arv <= 1'b1; rrd <= 1'b1;
    forever
    begin
      @(posedge sys_clk);
      if (arv && arr === 1'b1) arv <= 1'b0;
      if (rv === 1'b1)
      begin
        rd = rdata;
        rr = rresp;
        break;
      end
    end
    rrd <= 1'b0;
  endtask
  task automatic widle;
    for (int k = 0; k < 60; k++)
    begin
      rdt(`CCS_ADDR_COMMAND);
      if (rd[3:0] === `CCS_CMD_IDLE) break;
    end
    chk("command", rd[3:0], `CCS_CMD_IDLE);
  endtask
  task automatic frame;
    @(posedge sys_clk);
    freq <= 1'b1;
    @(posedge sys_clk);
    freq <= 1'b0;
    repeat (5) @(posedge sys_clk);
  endtask
  function automatic logic [7:0] cfgb(input int n);
    return n == 6 ? `CCS_POLL_B0 : n == 7 ? `CCS_POLL_B1 : 8'h30 + n[7:0];
  endfunction
  task automatic rback(input bit rnd);
    int moved = 0;
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_CONFIG);
    widle;
    rdt(`CCS_ADDR_STATUS);
    chk("fifo count", rd[9:3], 7'd25);
    for (int n = 0; n < 25; n++)
    begin
      rdt(`CCS_ADDR_FIFO);
      // Random fill only touches the third identifier slots.
      if (!rnd || !((n >= 2 && n <= 4) || (n >= 8 && n <= 13) || n == 24))
        chk("config byte", rd[7:0], n == 2 ? `CCS_ID1_FIXED : cfgb(n));
      else if (rd[7:0] !== (n == 2 ? `CCS_ID1_FIXED : cfgb(n)))
        moved++;
    end
    if (rnd)
      chk("random bytes", moved != 0, 1'b1);
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #600000;
    err_total++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[3:0], `CCS_CMD_IDLE);
    for (i = 0; i < 25; i++) wr(`CCS_ADDR_FIFO, {24'h0, cfgb(i)});
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_CONFIG);
    widle;
    rdt(`CCS_ADDR_STATUS);
    chk("fifo count", rd[9:3], 7'd0);
    rdt(`CCS_ADDR_FLAGS);
    chk("idle flag", rd[0], 1'b1);
    wr(`CCS_ADDR_FLAGS, 32'h1);
    rdt(`CCS_ADDR_FLAGS);
    chk("idle flag", rd[0], 1'b0);
    rback(1'b0);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_RANDOM);
    widle;
    rback(1'b1);
    wr(`CCS_ADDR_CONTROL, 32'h18);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_CRC);
    rdt(`CCS_ADDR_CRC);
    chk("crc", rd[15:0], `CCS_CRC_PRESET3);
    wr(`CCS_ADDR_FIFO, 32'h31);
    rdt(`CCS_ADDR_STATUS);
    chk("fifo count", rd[9:3], 7'd0);
    rdt(`CCS_ADDR_CRC);
    chk("crc", rd[15:0], 16'h2f8d);
    wr(`CCS_ADDR_COMMAND, 32'h27);
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[5:0], 6'h23);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_IDLE);
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[5:0], 6'h00);
    wr(`CCS_ADDR_CONTROL, 32'h0);
    for (i = 0; i < 3; i++) wr(`CCS_ADDR_FIFO, 32'h0c + i);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_TRANSMIT);
    widle;
    chk("last sent", last_tx, 8'h0e);
    rdt(`CCS_ADDR_STATUS);
    chk("fifo count", rd[9:3], 7'd0);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_RECEIVE);
    frame;
    widle;
    rdt(`CCS_ADDR_STATUS);
    chk("fifo count", rd[9:3], 7'd1);
    wr(`CCS_ADDR_CONTROL, 32'h2);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_RECEIVE);
    frame;
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[3:0], `CCS_CMD_RECEIVE);
    wr(`CCS_ADDR_CONTROL, 32'h0);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_TRANSCEIVE);
    rdt(`CCS_ADDR_COMMAND);
    chk("receive first", {txa, rxa}, 2'b01);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_AUTOCOLL);
    repeat (20) @(posedge sys_clk);
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[3:0], `CCS_CMD_AUTOCOLL);
    chk("mode detect", mda, 1'b1);
    chk("crc force", crf, 1'b1);
    ta <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("crc force", crf, 1'b0);
    rf <= 1'b1;
    det <= 1'b1;
    frame;
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[3:0], `CCS_CMD_TRANSCEIVE);
    rdt(`CCS_ADDR_FLAGS);
    chk("field flags", rd[2:1], 2'b01);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_IDLE);
    det <= 1'b0;
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_SOFTRESET);
    widle;
    chk("soft reset pulses", srp_n, 1);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_AUTH);
    rdt(`CCS_ADDR_COMMAND);
    chk("command", rd[3:0], `CCS_CMD_AUTH);
    ad <= 1'b1;
    @(posedge sys_clk);
    ad <= 1'b0;
    widle;
    rdt(`CCS_ADDR_STATUS);
    i = rd[9:3];
    wr(`CCS_ADDR_CONTROL, 32'h20);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_CRC);
    repeat (30) @(posedge sys_clk);
    rdt(`CCS_ADDR_STATUS);
    chk("self test bytes", rd[9:3], i + 24);
    wr(`CCS_ADDR_COMMAND, `CCS_CMD_IDLE);
    rdt(12'h100);
    chk("resp", rr, `CCS_RESP_SLVERR);
    chk("data", rd, 32'h0);
    close_out;
  end
endmodule
bind ccs_sequencer ccs_checker chk_i (.sys_clk(sys_clk), .rst(rst),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .tx_active(tx_active), .rx_active(rx_active),
  .mode_detect_active(mode_detect_active), .crc_force(crc_force),
  .soft_reset_pulse(soft_reset_pulse));
`default_nettype wire
